//--- owl_link.sv
/*
  Device end of the one-wire calibration link: frame receiver, byte
  transmitter, power-up command window, command session and output pacing.
  Assumes line_i is synchronous to clock_i and that the analog and
  correction logic answer cmd_valid_o with cmd_done_i on success.
*/
//
// Contract
// - Check both parities and edge time-outs
// - Send A5 after successful command
// - Bytes are start, eight data, parity
// - Bridge high byte first, top bits zero
// - Hold line high 32 us between bytes
// - Temperature mode sends three data bytes
// - Memory readout is fourteen byte packet
// - Idle gap between packets per rate
// - Bit rate 32 kHz or 8 kHz
// - Temperature measured every 128/64/16/8 outputs
// - Slow rates power down, then settle phases
// - Listen 6 ms after reset, then normal
// - Only enter-session first opens command session
// - Session executes commands until begin-normal
// - Normal mode presents configured output type
// - Bits duty coded 50/75/25 percent
// - Enter-session command byte is 50h
// - Begin-normal is 40h with data 00h
`timescale 1ns/1ps
module owl_link import owl_pkg::*; #(
  parameter int unsigned WIN_CYCLES   = WIN_CYC,
  parameter int unsigned IDLE0_CYCLES = IDLE0_CYC,
  parameter int unsigned IDLE1_CYCLES = IDLE1_CYC,
  parameter int unsigned IDLE2_CYCLES = IDLE2_CYC,
  parameter int unsigned IDLE3_CYCLES = IDLE3_CYC,
  parameter int unsigned SLOW_CYCLES  = BIT_SLOW_CYC,
  parameter int unsigned PON_CYCLES   = PON_CYC,
  parameter int unsigned CONV_CYCLES  = CONV_CYC,
  parameter int unsigned CALC_CYCLES  = CALC_CYC,
  parameter int unsigned RXTO_CYCLES  = RX_TO_CYC
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  // One-wire line
  input  wire logic         line_i,
  output logic              line_o,
  output logic              line_oe_n_o,
  // Stored configuration
  input  wire logic [1:0]   update_rate_i,
  input  wire logic [1:0]   out_cfg_i,
  // Measurement and memory data
  input  wire logic [13:0]  bridge_i,
  input  wire logic [7:0]   temp_i,
  input  wire logic [111:0] mem_data_i,
  // Command execution
  input  wire logic         cmd_done_i,
  output logic              cmd_valid_o,
  output logic [7:0]        cmd_byte_o,
  output logic [7:0]        cmd_data_o,
  // Status
  output logic              enter_command_session_o,
  output logic              normal_measurement_mode_o,
  output logic              frame_err_o,
  output logic              meas_start_o,
  output logic              temp_meas_o,
  output logic              power_down_o,
  output logic [1:0]        out_sel_o
);
  localparam int unsigned PHASES = PON_CYCLES + SETL_CYC + CONV_CYCLES + CALC_CYCLES;

  if (IDLE1_CYCLES <= PHASES || IDLE2_CYCLES <= PHASES || IDLE3_CYCLES <= PHASES ||
      IDLE0_CYCLES == 0 || SLOW_CYCLES < 4 || SLOW_CYCLES >= 8192 || RXTO_CYCLES >= 65536 ||
      IDLE3_CYCLES >= 2**24 || WIN_CYCLES >= 2**24 || WIN_CYCLES == 0) begin : g_chk
    $error("owl_link: timing parameters out of range");
  end

  typedef struct packed {
    owl_mode_t        mode;
    owl_seq_t         seq;
    logic [23:0]      tmr;
    owl_rx_t          rx;
    logic [15:0]      rx_cnt;
    logic [15:0]      rx_ref;
    logic [4:0]       rx_n;
    logic [17:0]      rx_sh;
    logic             rx_prev;
    owl_tx_t          tx;
    logic             tx_busy;
    logic [12:0]      tx_per;
    logic [12:0]      bit_tmr;
    logic [3:0]       bit_idx;
    logic [8:0]       tx_word;
    logic [3:0]       tx_left;
    logic [13:0][7:0] pkt;
    logic             pend_ack;
    logic [7:0]       temp_cnt;
    logic             line;
    logic             oe_n;
    logic             cmd_valid;
    logic [7:0]       cmd_byte;
    logic [7:0]       cmd_data;
    logic             frame_err;
    logic             meas_start;
    logic             temp_meas;
    logic             power_down;
    logic [1:0]       out_sel;
    logic             sess;
    logic             norm;
  } owl_state_t;

  owl_state_t   q;
  owl_state_t   n;
  logic         fall;
  logic         rise;
  logic         bitv;
  logic         nb;
  logic         frame_done;
  logic         frame_ok;
  logic         frame_bad;
  logic         go;
  logic [17:0]  sh;
  logic [111:0] go_pkt;
  logic [3:0]   go_len;
  logic [7:0]   rx_cmd;
  logic [7:0]   rx_dat;

  assign rx_cmd = sh[17:10];
  assign rx_dat = sh[8:1];

  // High time of a bit: start 50 %, one 75 %, zero 25 %
  function automatic logic [12:0] hi_cyc(input logic st, input logic b, input logic [12:0] p);
    if (st) return p >> 1;
    return b ? p - (p >> 2) : p >> 2;
  endfunction

  // Gap after a packet; slow rates leave room for the wake-up phases
  function automatic logic [23:0] gap_cyc(input logic [1:0] r);
    unique case (r)
      2'h0: return 24'(IDLE0_CYCLES - 1);
      2'h1: return 24'(IDLE1_CYCLES - PHASES - 1);
      2'h2: return 24'(IDLE2_CYCLES - PHASES - 1);
      2'h3: return 24'(IDLE3_CYCLES - PHASES - 1);
    endcase
  endfunction

  always_comb begin
    n = q;
    n.cmd_valid = 1'b0;
    n.meas_start = 1'b0;
    n.rx_prev = line_i;
    fall = q.rx_prev & ~line_i;
    rise = ~q.rx_prev & line_i;
    bitv = q.rx_cnt < q.rx_ref;  // Shorter low than the start bit is a one
    sh = {q.rx_sh[16:0], bitv};
    frame_done = 1'b0;
    frame_bad = 1'b0;
    go = 1'b0;
    go_pkt = '0;
    go_len = '0;
    nb = (q.bit_idx == 4'h0) ? q.tx_word[8] : q.tx_word[7];

    // Listen only while not talking: the line is half duplex
    unique case (q.rx)
      RX_IDLE: begin
        if (q.mode != MD_NORMAL && !q.tx_busy && fall) begin
          n.rx = RX_LOW;
          n.rx_cnt = '0;
          n.rx_n = '0;
        end
      end
      RX_LOW: begin
        n.rx_cnt = q.rx_cnt + 16'h1;
        if (rise) begin
          n.rx_cnt = '0;
          n.rx_n = q.rx_n + 5'h1;
          n.rx = RX_HIGH;
          if (q.rx_n == 5'h0) n.rx_ref = q.rx_cnt;
          else n.rx_sh = sh;
          if (q.rx_n == 5'(FRAME_BITS - 1)) begin
            frame_done = 1'b1;
            n.rx = RX_IDLE;
          end
        end
      end
      RX_HIGH: begin
        n.rx_cnt = q.rx_cnt + 16'h1;
        if (fall) begin
          n.rx = RX_LOW;
          n.rx_cnt = '0;
        end
      end
      default: n.rx = RX_IDLE;
    endcase
    if (q.rx != RX_IDLE && !rise && !fall && q.rx_cnt == 16'(RXTO_CYCLES - 1)) begin
      n.rx = RX_IDLE;
      frame_bad = 1'b1;
    end
    frame_ok = frame_done && !(^sh[17:9]) && !(^sh[8:0]);
    if (frame_done && !frame_ok) frame_bad = 1'b1;
    n.frame_err = frame_bad;  // Dropped: nothing below sees it

    // Transmitter: each byte is start, eight data bits MSB first, even parity
    unique case (q.tx)
      TX_IDLE: n.bit_tmr = '0;
      TX_LOW: begin
        if (q.bit_tmr == 13'h0) begin
          n.tx = TX_HIGH;
          n.line = 1'b1;
          n.bit_tmr = hi_cyc(q.bit_idx == 4'h0, q.tx_word[8], q.tx_per) - 13'h1;
        end else n.bit_tmr = q.bit_tmr - 13'h1;
      end
      TX_HIGH: begin
        if (q.bit_tmr != 13'h0) n.bit_tmr = q.bit_tmr - 13'h1;
        else if (q.bit_idx == 4'(BYTE_BITS - 1)) begin
          n.tx_left = q.tx_left - 4'h1;
          if (q.tx_left == 4'h1) begin
            n.tx = TX_IDLE;
            n.tx_busy = 1'b0;
            n.oe_n = 1'b1;
          end else begin
            n.tx = TX_STOP;
            n.bit_tmr = 13'(STOP_CYC - 1);
          end
        end else begin
          n.bit_idx = q.bit_idx + 4'h1;
          if (q.bit_idx != 4'h0) n.tx_word = {q.tx_word[7:0], 1'b0};
          n.tx = TX_LOW;
          n.line = 1'b0;
          n.bit_tmr = q.tx_per - hi_cyc(1'b0, nb, q.tx_per) - 13'h1;
        end
      end
      TX_STOP: begin
        if (q.bit_tmr != 13'h0) n.bit_tmr = q.bit_tmr - 13'h1;
        else begin
          n.tx_word = {q.pkt[0], ^q.pkt[0]};
          n.pkt = q.pkt >> 8;
          n.bit_idx = 4'h0;
          n.tx = TX_LOW;
          n.line = 1'b0;
          n.bit_tmr = q.tx_per - hi_cyc(1'b1, 1'b0, q.tx_per) - 13'h1;
        end
      end
    endcase

    unique case (q.mode)
      MD_WINDOW: begin
        n.tmr = q.tmr - 24'h1;
        if (frame_ok && rx_cmd == CMD_ENTER_SESSION) begin
          n.mode = MD_SESSION;
          go = 1'b1;
          go_pkt = 112'(ACK_BYTE);
          go_len = 4'h1;
        end else if (q.tmr == 24'h0) begin
          n.mode = MD_NORMAL;
          n.seq = SQ_GAP;
          n.tmr = gap_cyc(update_rate_i);
        end
      end
      MD_SESSION: begin
        if (q.pend_ack && cmd_done_i) begin
          n.pend_ack = 1'b0;
          go = 1'b1;
          go_pkt = 112'(ACK_BYTE);
          go_len = 4'h1;
        end
        if (frame_ok) begin
          if (rx_cmd == CMD_BEGIN_NORMAL && rx_dat == DATA_BEGIN_NORMAL) begin
            n.mode = MD_NORMAL;
            n.seq = SQ_GAP;
            n.tmr = gap_cyc(update_rate_i);
            go = 1'b1;
            go_pkt = 112'(ACK_BYTE);
            go_len = 4'h1;
          end else if (rx_cmd == CMD_ENTER_SESSION) begin
            go = 1'b1;
            go_pkt = 112'(ACK_BYTE);
            go_len = 4'h1;
          end else if (rx_cmd == CMD_READ_MEMORY) begin
            go = 1'b1;
            go_pkt = mem_data_i;
            go_len = 4'(MEM_BYTES);
          end else begin
            n.cmd_valid = 1'b1;
            n.cmd_byte = rx_cmd;
            n.cmd_data = rx_dat;
            n.pend_ack = 1'b1;
          end
        end
      end
      MD_NORMAL: begin
        if (q.tmr != 24'h0 && q.seq inside {SQ_GAP, SQ_PON, SQ_SETL, SQ_CONV, SQ_CALC})
          n.tmr = q.tmr - 24'h1;
        else begin
          unique case (q.seq)
            SQ_GAP: begin
              if (update_rate_i == RATE_1MS) n.seq = SQ_LOAD;
              else begin
                n.seq = SQ_PON;
                n.tmr = 24'(PON_CYCLES - 1);
              end
            end
            SQ_PON: begin
              n.seq = SQ_SETL;
              n.tmr = 24'(SETL_CYC - 1);
            end
            SQ_SETL: begin
              n.seq = SQ_CONV;
              n.tmr = 24'(CONV_CYCLES - 1);
            end
            SQ_CONV: begin
              n.seq = SQ_CALC;
              n.tmr = 24'(CALC_CYCLES - 1);
            end
            SQ_CALC: n.seq = SQ_LOAD;
            SQ_LOAD: begin
              if (!q.tx_busy) begin
                n.meas_start = 1'b1;
                n.temp_meas = q.temp_cnt == 8'h0;
                n.temp_cnt = (q.temp_cnt >= TEMP_EVERY[update_rate_i] - 8'h1) ? 8'h0
                                                                         : q.temp_cnt + 8'h1;
                if (out_cfg_i[1]) begin
                  go = 1'b1;
                  go_pkt = {88'h0, temp_i, bridge_i[7:0], 2'b00, bridge_i[13:8]};
                  go_len = out_cfg_i[0] ? 4'h3 : 4'h2;
                end
                n.seq = SQ_SEND;
              end
            end
            SQ_SEND: begin
              if (!q.tx_busy) begin
                n.seq = SQ_GAP;
                n.tmr = gap_cyc(update_rate_i);
              end
            end
          endcase
        end
      end
      default: n.mode = MD_WINDOW;
    endcase

    // A packet starts through a zero-length stop so the byte loader is shared
    if (go) begin
      n.pkt = go_pkt;
      n.tx_left = go_len;
      n.tx_busy = 1'b1;
      n.tx = TX_STOP;
      n.bit_tmr = '0;
      n.oe_n = 1'b0;
      n.line = 1'b1;
      n.tx_per = update_rate_i[1] ? 13'(SLOW_CYCLES) : 13'(BIT_FAST_CYC);
    end
    n.power_down = n.mode == MD_NORMAL && n.seq == SQ_GAP && update_rate_i != RATE_1MS;
    if (n.mode == MD_NORMAL) n.out_sel = out_cfg_i;
    // Mode flags are registered so the outputs need no decode
    n.sess = n.mode == MD_SESSION;
    n.norm = n.mode == MD_NORMAL;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      q <= '0;
      q.tmr <= 24'(WIN_CYCLES - 1);
      q.line <= 1'b1;
      q.oe_n <= 1'b1;
      q.rx_prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign line_o = q.line;
  assign line_oe_n_o = q.oe_n;
  assign cmd_valid_o = q.cmd_valid;
  assign cmd_byte_o = q.cmd_byte;
  assign cmd_data_o = q.cmd_data;
  assign enter_command_session_o = q.sess;
  assign normal_measurement_mode_o = q.norm;
  assign frame_err_o = q.frame_err;
  assign meas_start_o = q.meas_start;
  assign temp_meas_o = q.temp_meas;
  assign power_down_o = q.power_down;
  assign out_sel_o = q.out_sel;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_ack_req;
    q.mode == MD_SESSION && q.pend_ack && cmd_done_i && !frame_ok;
  endsequence
  sequence s_ack_sent;
    q.tx_busy && q.tx_left == 4'h1 && q.pkt[0] == ACK_BYTE ##1 q.tx_word == {ACK_BYTE, 1'b0};
  endsequence

  ack_on_done_a: assert property (s_ack_req |=> s_ack_sent)
    else $error("acknowledge byte not sent");
  bad_frame_drop_a: assert property (frame_bad && !(q.pend_ack && cmd_done_i)
                                     |=> !q.cmd_valid && !q.tx_busy)
    else $error("bad frame acted upon");
  window_ignore_a: assert property (q.mode == MD_WINDOW && frame_ok && q.tmr != 24'h0 &&
                                    rx_cmd != CMD_ENTER_SESSION |=> q.mode == MD_WINDOW)
    else $error("window left on wrong command");
  window_expire_a: assert property (q.mode == MD_WINDOW && q.tmr == 24'h0 && !frame_ok
                                    |=> q.mode == MD_NORMAL)
    else $error("window did not expire");
  session_hold_a: assert property (q.mode == MD_SESSION && !(frame_ok &&
                                   rx_cmd == CMD_BEGIN_NORMAL && rx_dat == DATA_BEGIN_NORMAL)
                                   |=> q.mode == MD_SESSION)
    else $error("session left unexpectedly");
  stop_time_a: assert property (q.tx == TX_HIGH && q.bit_tmr == 13'h0 &&
                                q.bit_idx == 4'h9 && q.tx_left > 4'h1
                                |=> q.tx == TX_STOP && q.bit_tmr == 13'(STOP_CYC - 1) ##1 q.line)
    else $error("stop time wrong");
  bridge_pad_a: assert property (q.mode == MD_NORMAL && q.seq == SQ_LOAD && !q.tx_busy &&
                                 out_cfg_i[1] |=> q.pkt[0][7:6] == 2'b00 &&
                                 q.tx_left == ($past(out_cfg_i[0]) ? 4'h3 : 4'h2))
    else $error("bridge packet malformed");
  bit_rate_a: assert property (go |=> q.tx_per ==
                               ($past(update_rate_i[1]) ? 13'(SLOW_CYCLES) : 13'(BIT_FAST_CYC)))
    else $error("bit period wrong");
  start_duty_a: assert property (q.tx == TX_STOP && q.bit_tmr == 13'h0 |=> q.tx == TX_LOW &&
                                 q.bit_tmr == q.tx_per - (q.tx_per >> 1) - 13'h1)
    else $error("start bit duty wrong");
endmodule

//--- owl_pkg.sv
/*
  Constants and types for the one-wire calibration link.
  Assumes a single 40 MHz clock; all timing figures are derived from it here.
*/
package owl_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned CLK_NS       = 1_000_000_000 / CLK_HZ;

  // Times in ns
  localparam int unsigned BIT_FAST_NS  = 31_250;
  localparam int unsigned BIT_SLOW_NS  = 125_000;
  localparam int unsigned STOP_NS      = 32_000;
  localparam int unsigned WIN_NS       = 6_000_000;
  localparam int unsigned IDLE0_NS     = 1_000_000;
  localparam int unsigned IDLE1_NS     = 4_850_000;
  localparam int unsigned IDLE2_NS     = 22_500_000;
  localparam int unsigned IDLE3_NS     = 118_000_000;
  localparam int unsigned PON_NS       = 128_000;
  localparam int unsigned SETL_NS      = 64_000;
  localparam int unsigned CONV_NS      = 768_000;
  localparam int unsigned CALC_NS      = 160_000;
  localparam int unsigned RX_TO_NS     = 500_000;

  localparam int unsigned BIT_FAST_CYC = (BIT_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BIT_SLOW_CYC = (BIT_SLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STOP_CYC     = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WIN_CYC      = (WIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned IDLE0_CYC    = (IDLE0_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned IDLE1_CYC    = (IDLE1_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned IDLE2_CYC    = (IDLE2_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned IDLE3_CYC    = (IDLE3_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PON_CYC      = (PON_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETL_CYC     = (SETL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CONV_CYC     = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CALC_CYC     = (CALC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RX_TO_CYC    = (RX_TO_NS + CLK_NS - 1) / CLK_NS;

  localparam int unsigned FRAME_BITS   = 19;
  localparam int unsigned BYTE_BITS    = 10;
  localparam int unsigned MEM_BYTES    = 14;

  localparam logic [7:0] ACK_BYTE          = 8'ha5;
  localparam logic [7:0] CMD_ENTER_SESSION = 8'h50;
  localparam logic [7:0] CMD_BEGIN_NORMAL  = 8'h40;
  localparam logic [7:0] DATA_BEGIN_NORMAL = 8'h00;
  localparam logic [7:0] CMD_READ_MEMORY   = 8'h00;

  localparam logic [1:0] RATE_1MS          = 2'h0;
  // Temperature interval indexed by update rate code
  localparam logic [3:0][7:0] TEMP_EVERY   = {8'h08, 8'h10, 8'h40, 8'h80};

  typedef enum logic [1:0] {MD_WINDOW, MD_SESSION, MD_NORMAL} owl_mode_t;
  typedef enum logic [2:0] {SQ_GAP, SQ_PON, SQ_SETL, SQ_CONV, SQ_CALC, SQ_LOAD,
                            SQ_SEND} owl_seq_t;
  typedef enum logic [1:0] {RX_IDLE, RX_LOW, RX_HIGH} owl_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_LOW, TX_HIGH, TX_STOP} owl_tx_t;
endpackage

//--- owl_master_model.sv
/*
  Calibration master model: sends duty-coded command frames and decodes
  the device's bytes from the resolved wire.
  Assumes the bench resolves the wire with a pull-up when nobody drives.
*/
`timescale 1ns/1ps
module owl_master_model #(
  parameter int P = 40
) (
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic wire_i,
  output logic      drive_en_o,
  output logic      drive_o
);
  logic [7:0] rxq[$];
  logic [7:0] sh;
  logic       sending = 1'b0;
  logic       prev = 1'b1;
  int         lo = 0;
  int         nbit = 0;
  int         bad_cnt = 0;

  initial begin
    drive_en_o = 1'b0;
    drive_o = 1'b1;
  end

  // Frame is start, command, parity, data, parity; nb cuts it short
  task automatic send_frame(input logic [7:0] c, input logic [7:0] d,
                            input logic flip, input int nb);
    logic [18:0] f;
    int          lw;
    f = {1'b0, c, ^c ^ flip, d, ^d};
    for (int i = 0; i < nb; i++) begin
      lw = (i == 0) ? P / 2 : (f[18 - i] ? P / 4 : P - P / 4);
      @(posedge clock_i);
      sending <= 1'b1;
      drive_en_o <= 1'b1;
      drive_o <= 1'b0;
      repeat (lw) @(posedge clock_i);
      // Release for the high phase: the pull-up lifts the wire
      drive_o <= 1'b1;
      drive_en_o <= 1'b0;
      // The device may answer right after the last rise
      if (i < nb - 1) repeat (P - lw - 1) @(posedge clock_i);
    end
    @(posedge clock_i);
    sending <= 1'b0;
  endtask

  // A bit is judged at its rise by how long the line stayed low
  always @(posedge clock_i) begin
    prev <= wire_i;
    if (reset_i || sending) begin
      nbit <= 0;
      lo <= 0;
    end else if (!wire_i) begin
      lo <= lo + 1;
    end else if (!prev) begin
      lo <= 0;
      if (nbit == 0 && lo != P / 2)
        bad_cnt <= bad_cnt + 1;
      if (nbit > 0 && lo != P / 4 && lo != P - P / 4)
        bad_cnt <= bad_cnt + 1;
      if (nbit > 0 && nbit < 9)
        sh <= {sh[6:0], lo == P / 4};
      nbit <= (nbit == 9) ? 0 : nbit + 1;
      if (nbit == 9) begin
        if (^{sh, lo == P / 4})
          bad_cnt <= bad_cnt + 1;
        rxq.push_back(sh);
      end
    end
  end
endmodule

//--- testbench.sv
/*
  Self-checking bench for owl_link against a master model on the wire.
  Assumes shortened timing parameters; expected bytes come from a queue model.
*/
`timescale 1ns/1ps
module testbench;
  import owl_pkg::*;
  localparam int P = 40;
  localparam int WIN = 3000;
  logic         clock_i = 1'b0;
  logic         reset_i = 1'b1;
  logic         cmd_done_i;
  logic [1:0]   update_rate_i;
  logic [1:0]   out_cfg_i;
  logic [13:0]  bridge_i;
  logic [7:0]   temp_i;
  logic [111:0] mem_data_i;
  logic         line_o, oe_n, cmd_valid_o, sess, norm, ferr, mstart, tmeas, pdown;
  logic         m_en, m_val, pd_seen;
  logic [7:0]   cmd_byte_o, cmd_data_o, c, d, t;
  logic [13:0]  b;
  logic [127:0] r;
  logic [1:0]   out_sel_o;
  logic [7:0]   eq[$];
  logic         tq[$];
  int           seed = 71;
  int           error_cnt = 0;
  int           num_checks = 0;
  int           ferr_n = 0;
  int           cv_n = 0;
  // Pull-up holds the wire high when neither end drives
  wire          line_w = !oe_n ? line_o : (m_en ? m_val : 1'b1);

  always #12.5 clock_i = ~clock_i;

  owl_link #(.WIN_CYCLES(WIN), .IDLE0_CYCLES(300), .IDLE1_CYCLES(3000),
    .IDLE2_CYCLES(3000), .IDLE3_CYCLES(3000), .SLOW_CYCLES(P), .PON_CYCLES(10),
    .CONV_CYCLES(20), .CALC_CYCLES(10), .RXTO_CYCLES(100)) dut (
    .clock_i(clock_i), .reset_i(reset_i), .line_i(line_w), .line_o(line_o),
    .line_oe_n_o(oe_n), .update_rate_i(update_rate_i), .out_cfg_i(out_cfg_i),
    .bridge_i(bridge_i), .temp_i(temp_i), .mem_data_i(mem_data_i),
    .cmd_done_i(cmd_done_i), .cmd_valid_o(cmd_valid_o), .cmd_byte_o(cmd_byte_o),
    .cmd_data_o(cmd_data_o), .enter_command_session_o(sess),
    .normal_measurement_mode_o(norm), .frame_err_o(ferr), .meas_start_o(mstart),
    .temp_meas_o(tmeas), .power_down_o(pdown), .out_sel_o(out_sel_o));

  owl_master_model #(.P(P)) m (
    .clock_i(clock_i), .reset_i(reset_i), .wire_i(line_w),
    .drive_en_o(m_en), .drive_o(m_val));

  always @(posedge clock_i) begin
    if (ferr === 1'b1) ferr_n++;
    if (cmd_valid_o === 1'b1) cv_n++;
    if (pdown === 1'b1) pd_seen = 1'b1;
    if (mstart === 1'b1) tq.push_back(tmeas);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic expect_bytes(input string what);
    logic [7:0] got;
    while (eq.size() > 0) begin
      // Give up on a missing reply, as the master would
      for (int i = 0; i < 40000 && m.rxq.size() == 0; i++) @(posedge clock_i);
      got = (m.rxq.size() > 0) ? m.rxq.pop_front() : 8'hxx;
      chk(got, eq.pop_front(), what);
    end
    // The last bit's high phase still holds the wire; let the device release it
    repeat (P) @(posedge clock_i);
  endtask

  task automatic do_reset;
    @(posedge clock_i);
    reset_i <= 1'b1;
    cmd_done_i <= 1'b0;
    out_cfg_i <= 2'h0;
    bridge_i <= 14'h0;
    temp_i <= 8'h0;
    mem_data_i <= 112'h0;
    // Only the slow rates match the model's bit period; the code sets the temperature interval
    update_rate_i <= 2'h2 | 2'($random(seed) & 1);
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    m.rxq.delete();
    tq.delete();
    pd_seen = 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clock_i);
    error_cnt++;
    close_out();
  end

  initial begin
    do_reset();
    repeat (WIN + 20) @(posedge clock_i);
    chk(8'(norm), 8'h1, "window expiry");
    do_reset();
    m.send_frame(8'h30, 8'h12, 1'b0, 19);
    repeat (300) @(posedge clock_i);
    chk(8'(sess), 8'h0, "wrong first command");
    chk(8'(m.rxq.size()), 8'h0, "no reply in window");
    m.send_frame(CMD_ENTER_SESSION, 8'($random(seed)), 1'b0, 19);
    eq.push_back(ACK_BYTE);
    expect_bytes("session ack");
    chk(8'(sess), 8'h1, "session entered");
    m.send_frame(8'h60, 8'h55, 1'b1, 19);
    m.send_frame(8'h60, 8'h55, 1'b0, 7);
    repeat (300) @(posedge clock_i);
    chk(8'(ferr_n), 8'h2, "frame errors");
    chk(8'(cv_n + m.rxq.size()), 8'h0, "bad frames silent");
    for (int k = 0; k < 4; k++) begin
      c = 8'h60 + 8'(($random(seed) & 7) << 4);
      d = 8'($random(seed));
      m.send_frame(c, d, 1'b0, 19);
      repeat (20) @(posedge clock_i);
      chk(8'(cv_n), 8'(k + 1), "command pulse");
      chk(cmd_byte_o, c, "command byte");
      chk(cmd_data_o, d, "data byte");
      cmd_done_i <= 1'b1;
      @(posedge clock_i);
      cmd_done_i <= 1'b0;
      eq.push_back(ACK_BYTE);
      expect_bytes("command ack");
    end
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    mem_data_i <= r[111:0];
    for (int i = 0; i < 14; i++) eq.push_back(r[8 * i +: 8]);
    m.send_frame(CMD_READ_MEMORY, 8'h00, 1'b0, 19);
    expect_bytes("readout");
    b = 14'($random(seed));
    t = 8'($random(seed));
    bridge_i <= b;
    temp_i <= t;
    out_cfg_i <= 2'h2;
    m.send_frame(CMD_BEGIN_NORMAL, DATA_BEGIN_NORMAL, 1'b0, 19);
    eq.push_back(ACK_BYTE);
    expect_bytes("normal ack");
    chk(8'(norm), 8'h1, "normal mode");
    eq.push_back({2'h0, b[13:8]});
    eq.push_back(b[7:0]);
    expect_bytes("bridge packet");
    chk(8'(out_sel_o), 8'h2, "output select");
    out_cfg_i <= 2'h3;
    eq.push_back({2'h0, b[13:8]});
    eq.push_back(b[7:0]);
    eq.push_back(t);
    expect_bytes("temperature packet");
    chk(8'(tq.size() >= 2 ? {tq[0], tq[1]} : 2'h0), 8'h2, "temperature turns");
    chk(8'(pd_seen), 8'h1, "power down");
    chk(8'(m.bad_cnt), 8'h0, "bit coding");
    close_out();
  end
endmodule
